// *** src/psf_pkg.sv ***
/*
  Shared constants and types of the port status and fault flag block.
  Assumes one 100 MHz clock and a byte-wide serial-management register port.
*/
package psf_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_MISC_STATE = 8'h0f;
  localparam logic [7:0] ADDR_FAULT_STATE = 8'h10;
  localparam logic [7:0] ADDR_EVENT_STATE = 8'h11;
  localparam logic [7:0] ADDR_PROFILE_A = 8'h12;
  localparam logic [7:0] ADDR_PROFILE_B = 8'h13;
  localparam logic [7:0] ADDR_PIN_STATE = 8'h14;

  // fault_state fields
  localparam int FLT_ERR = 7;
  localparam int FLT_DRAIN = 6;
  localparam int FLT_RESET = 5;
  localparam int FLT_UNDERV = 4;
  localparam int FLT_HEAT = 3;
  localparam int FLT_SRC_OV = 2;
  localparam int FLT_BACK_V = 1;
  localparam int FLT_OVERCUR = 0;
  localparam logic [7:0] FAULT_COND_MASK = 8'h5f;

  // event_state fields
  localparam int EVT_QUOTA = 7;
  localparam int EVT_CC = 4;
  localparam int EVT_THROTTLE = 3;
  localparam int EVT_LIGHT = 2;
  localparam int EVT_UNPLUG = 1;
  localparam int EVT_PLUG = 0;
  localparam logic [7:0] EVENT_FLAG_MASK = 8'h8f;

  // misc_state fields
  localparam int MISC_ALERT = 5;
  localparam int MISC_ATTACH = 4;
  localparam int MISC_LOAD = 3;
  localparam int MISC_EMUL = 2;

  // Implemented profile bits, profile_state_b above profile_state_a
  localparam logic [15:0] PROFILE_MASK = 16'h7f9f;

  // Values after reset
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] FAULT_FLAGS_RESET = 8'h20;

  // Quota behaviour code that routes the quota flag to the interrupt pin
  localparam logic [1:0] QUOTA_ACT_ALERT = 2'h1;

  // Analog thresholds, applied by the comparators outside this block
  localparam int BACK_MARGIN_MV = 150;
  localparam int LIGHT_LOAD_UA = 6400;

  typedef enum logic {PSF_ACTIVE, PSF_ERROR} psf_mode_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } psf_reg_req_t;

  typedef struct packed {
    logic drain_fail;
    logic undervolt;
    logic overheat;
    logic source_overvolt;
    logic back_volt;
    logic over_limit;
    logic over_r2min;
  } psf_fault_cond_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic alert_act;
    logic attach_act;
    logic pwr_q;
    logic pwr_seen;
  } psf_main_st_t;

endpackage

// *** src/psf_flag_bank.sv ***
/*
  Bank of sticky flags: a set input per bit, a clear input per bit.
  Assumes set and clear are synchronous to clock; set wins over clear.
*/
`timescale 1ns/1ps
`default_nettype none
module psf_flag_bank
  import psf_pkg::*;
#(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0,
  parameter logic [W-1:0] MASK = '1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Per-bit controls
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // Flags
  output logic [W-1:0] flags
);
  typedef struct packed {
    logic [W-1:0] bits;
  } psf_bank_st_t;

  psf_bank_st_t state;
  psf_bank_st_t next_state;

  if (W < 1) begin : g_bad_width
    $error("psf_flag_bank needs W of at least one");
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    // An event in the clearing cycle must not be lost
    always_comb begin
      next_state.bits[i] = MASK[i] & (set[i] | (state.bits[i] & ~clr[i]));
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state.bits <= RST & MASK;
    end else begin
      state <= next_state;
    end
  end

  assign flags = state.bits;
endmodule
`default_nettype wire

// *** src/psf_err_ctrl.sv ***
/*
  Active and Error state control of the port.
  Assumes the caller drops the error only when no fault condition remains.
*/
`timescale 1ns/1ps
`default_nettype none
module psf_err_ctrl
  import psf_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Causes
  input wire logic any_flag,
  input wire logic drop,
  // State
  output var psf_mode_t mode,
  output logic err
);
  typedef struct packed {
    psf_mode_t mode;
  } psf_err_st_t;

  psf_err_st_t state;
  psf_err_st_t next_state;

  always_comb begin
    next_state = state;
    case (state.mode)
      PSF_ACTIVE: begin
        if (any_flag) begin
          next_state.mode = PSF_ERROR;
        end
      end
      PSF_ERROR: begin
        if (drop) begin
          next_state.mode = PSF_ACTIVE;
        end
      end
      default: begin
        next_state.mode = PSF_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state.mode <= PSF_ACTIVE;
    end else begin
      state <= next_state;
    end
  end

  assign mode = state.mode;
  assign err = (state.mode == PSF_ERROR);
endmodule
`default_nettype wire

// *** src/psf_port_status.sv ***
/*
  Status registers of a USB port power controller: fault flags with the
  Error state, event flags, emulation progress and the two open-drain pins.
  Assumes comparator levels and event pulses are synchronous to clock and
  that the serial-management front end issues one-cycle rd and wr strobes.
*/
// Function
// - Error flag sets by itself when any fault puts the port in Error.
// - Host writes zero to error flag; port returns Active only if fault-free.
// - Port stays in Error while any fault condition remains present.
// - With auto-recovery and no fault condition, error flag clears itself.
// - Error flag clears when port power enable is low and no fault condition remains.
// - Fault flags clear on read once condition gone, and with the error flag.
// - Any fault flag drives the interrupt pin and enters Error.
// - Drain failure flag sets when the bus node cannot be discharged.
// - Reset flag sets at power-up; clears on read or power enable toggle.
// - Reset flag never drives the interrupt pin.
// - Back-voltage flag sets when bus exceeds a supply by the margin.
// - Overcurrent flag needs current above both limit and region-two minimum.
// - Interrupt pin and error flag are independent signals.
// - Quota flag sets on delivered charge, alerts if selected, clears on read.
// - Quota flag also clears on quota clear command or quota disable.
// - Throttle and light-load flags clear on read; alert only when linked.
// - Light-load flag sets when bus current falls below the threshold.
// - Removal sets a clear-on-read flag and releases attach pin, no alert.
// - Attach sets a clear-on-read flag and asserts attach pin, no alert.
// - Constant-current bit shows bus current above the programmed limit.
// - Profile bits clear on power disable, new mode or removal.
// - Profile bits never touch the interrupt or attach pins.
`timescale 1ns/1ps
`default_nettype none
module psf_port_status
  import psf_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire psf_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Fault comparators
  input wire psf_fault_cond_t fault_cond,
  // Fault handling controls
  input wire logic port_power_enable,
  input wire logic autorecovery_en,
  // Charge quota
  input wire logic quota_reached,
  input wire logic quota_enable,
  input wire logic quota_clear_cmd,
  input wire logic [1:0] quota_action_sel,
  // General events
  input wire logic alert_link,
  input wire logic throttle_cond,
  input wire logic light_load_cond,
  input wire logic unplug_evt,
  input wire logic plug_in_evt,
  // Emulation progress
  input wire logic load_draw_flag,
  input wire logic emulating_flag,
  input wire logic [1:0] stim_pair_index,
  input wire logic new_mode_sel,
  input wire logic [7:0] profile_a_set,
  input wire logic [7:0] profile_b_set,
  input wire logic [7:0] control_pin_level,
  // Interrupt pin, open drain
  input wire logic alert_pin_in,
  output logic alert_pin_out,
  output logic alert_pin_oe_n,
  // Attach pin, open drain
  input wire logic attach_pin_in,
  output logic attach_pin_out,
  output logic attach_pin_oe_n,
  // Port state
  output var psf_mode_t mode
);
  psf_main_st_t state;
  psf_main_st_t next_state;

  logic err;
  logic [7:0] fault_flags;
  logic [7:0] event_flags;
  logic [15:0] profile_flags;
  logic [7:0] fault_set;
  logic [7:0] fault_clr;
  logic [7:0] event_set;
  logic [7:0] event_clr;
  logic [7:0] cond_vec;
  logic rd_fault;
  logic rd_event;
  logic host_clear;
  logic any_cond;
  logic any_flag;
  logic err_drop;
  logic pwr_toggle;
  logic profile_clr;
  logic alert_want;

  assign rd_fault = reg_req.rd && (reg_req.addr == ADDR_FAULT_STATE);
  assign rd_event = reg_req.rd && (reg_req.addr == ADDR_EVENT_STATE);

  // host clears error by writing zero
  assign host_clear = reg_req.wr && (reg_req.addr == ADDR_FAULT_STATE) && !reg_req.wdata[FLT_ERR];

  always_comb begin
    cond_vec = 8'h00;
    cond_vec[FLT_DRAIN] = fault_cond.drain_fail;
    cond_vec[FLT_UNDERV] = fault_cond.undervolt;
    cond_vec[FLT_HEAT] = fault_cond.overheat;
    cond_vec[FLT_SRC_OV] = fault_cond.source_overvolt;
    cond_vec[FLT_BACK_V] = fault_cond.back_volt;
    cond_vec[FLT_OVERCUR] = fault_cond.over_limit & fault_cond.over_r2min;
  end

  assign any_cond = |cond_vec;
  assign any_flag = |(fault_flags & FAULT_COND_MASK);
  assign pwr_toggle = state.pwr_seen && (port_power_enable != state.pwr_q);

  // auto-recovery, power disable; a live fault keeps Error
  assign err_drop = err && !any_cond && (host_clear || autorecovery_en || !port_power_enable);

  always_comb begin
    fault_set = cond_vec;
    // clear on read when gone, or with the error flag
    fault_clr = ((rd_fault ? ~cond_vec : 8'h00) | {8{err_drop}}) & FAULT_COND_MASK;
    // reset flag clears on read or power toggle
    fault_clr[FLT_RESET] = rd_fault | pwr_toggle;
  end

  // reset flag set at power-up via reset value
  psf_flag_bank #(
    .W(8),
    .RST(FAULT_FLAGS_RESET),
    .MASK(FAULT_COND_MASK | FAULT_FLAGS_RESET)
  ) u_fault_bank (
    .clock(clock),
    .rst(rst),
    .set(fault_set),
    .clr(fault_clr),
    .flags(fault_flags)
  );

  psf_err_ctrl u_err_ctrl (
    .clock(clock),
    .rst(rst),
    .any_flag(any_flag),
    .drop(err_drop),
    .mode(mode),
    .err(err)
  );

  always_comb begin
    event_set = 8'h00;
    event_set[EVT_QUOTA] = quota_reached;
    event_set[EVT_THROTTLE] = throttle_cond;
    event_set[EVT_LIGHT] = light_load_cond;
    event_set[EVT_UNPLUG] = unplug_evt;
    event_set[EVT_PLUG] = plug_in_evt;
    event_clr = rd_event ? EVENT_FLAG_MASK : 8'h00;
    event_clr[EVT_QUOTA] = rd_event | quota_clear_cmd | !quota_enable;
  end

  psf_flag_bank #(
    .W(8),
    .RST(REG_RESET),
    .MASK(EVENT_FLAG_MASK)
  ) u_event_bank (
    .clock(clock),
    .rst(rst),
    .set(event_set),
    .clr(event_clr),
    .flags(event_flags)
  );

  assign profile_clr = !port_power_enable | new_mode_sel | unplug_evt;

  psf_flag_bank #(
    .W(16),
    .RST({REG_RESET, REG_RESET}),
    .MASK(PROFILE_MASK)
  ) u_profile_bank (
    .clock(clock),
    .rst(rst),
    .set({profile_b_set, profile_a_set}),
    .clr({16{profile_clr}}),
    .flags(profile_flags)
  );

  // faults alert; reset flag excluded; profiles excluded
  // alert derived from flags, not from the error state
  always_comb begin
    alert_want = any_flag;
    if (event_flags[EVT_QUOTA] && (quota_action_sel == QUOTA_ACT_ALERT)) begin
      alert_want = 1'b1;
    end
    if (alert_link && (event_flags[EVT_THROTTLE] || event_flags[EVT_LIGHT])) begin
      alert_want = 1'b1;
    end
  end

  always_comb begin
    next_state = state;
    next_state.alert_act = alert_want;
    next_state.pwr_q = port_power_enable;
    next_state.pwr_seen = 1'b1;
    // attach asserts pin; removal releases it
    if (plug_in_evt) begin
      next_state.attach_act = 1'b1;
    end else if (unplug_evt) begin
      next_state.attach_act = 1'b0;
    end
    if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_MISC_STATE: begin
          next_state.rdata = REG_RESET;
          // pin mirrors, low on the wire means asserted
          next_state.rdata[MISC_ALERT] = !alert_pin_in;
          next_state.rdata[MISC_ATTACH] = !attach_pin_in;
          next_state.rdata[MISC_LOAD] = load_draw_flag;
          next_state.rdata[MISC_EMUL] = emulating_flag;
          next_state.rdata[1:0] = stim_pair_index;
        end
        ADDR_FAULT_STATE: begin
          next_state.rdata = fault_flags;
          next_state.rdata[FLT_ERR] = err;
        end
        ADDR_EVENT_STATE: begin
          next_state.rdata = event_flags;
          next_state.rdata[EVT_CC] = fault_cond.over_limit;
        end
        ADDR_PROFILE_A: begin
          next_state.rdata = profile_flags[7:0];
        end
        ADDR_PROFILE_B: begin
          next_state.rdata = profile_flags[15:8];
        end
        ADDR_PIN_STATE: begin
          next_state.rdata = control_pin_level;
        end
        default: begin
          next_state.rdata = REG_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state.rdata <= REG_RESET;
      state.alert_act <= 1'b0;
      state.attach_act <= 1'b0;
      state.pwr_q <= 1'b0;
      state.pwr_seen <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // Open drain: the output level is always low, the enable decides
  assign reg_rdata = state.rdata;
  assign alert_pin_out = 1'b0;
  assign alert_pin_oe_n = !state.alert_act;
  assign attach_pin_out = 1'b0;
  assign attach_pin_oe_n = !state.attach_act;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  property p_err_set;
    any_flag && !err |=> err;
  endproperty
  a_err_set: assert property (p_err_set) else $error("fault flag did not enter Error");

  property p_host_clear;
    err && host_clear && !any_cond |=> !err && ((fault_flags & FAULT_COND_MASK) == 8'h00);
  endproperty
  a_host_clear: assert property (p_host_clear) else $error("host clear not honoured");

  property p_err_hold;
    err && any_cond |=> err;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("Error left with fault present");

  property p_auto;
    err && autorecovery_en && !any_cond |=> !err;
  endproperty
  a_auto: assert property (p_auto) else $error("auto-recovery did not clear error");

  property p_pwr_off;
    err && !port_power_enable && !any_cond |=> !err;
  endproperty
  a_pwr_off: assert property (p_pwr_off) else $error("power disable did not clear error");

  property p_rd_clear;
    rd_fault && !any_cond |=> ((fault_flags & FAULT_COND_MASK) == 8'h00);
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("fault flag survived read");

  property p_alert_fault;
    any_flag |=> !alert_pin_oe_n && (err || $past(err_drop));
  endproperty
  a_alert_fault: assert property (p_alert_fault) else $error("fault did not alert");

  property p_reset_toggle;
    pwr_toggle |=> !fault_flags[FLT_RESET];
  endproperty
  a_reset_toggle: assert property (p_reset_toggle) else $error("reset flag kept after toggle");

  property p_quiet;
    !any_flag && !event_flags[EVT_QUOTA] && !alert_link |=> alert_pin_oe_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("alert without cause");

  property p_overcur;
    fault_cond.over_limit && !fault_cond.over_r2min && !fault_flags[FLT_OVERCUR] |=> !fault_flags[FLT_OVERCUR];
  endproperty
  a_overcur: assert property (p_overcur) else $error("overcurrent set below minimum");

  property p_quota_clr;
    (quota_clear_cmd || !quota_enable) && !quota_reached |=> !event_flags[EVT_QUOTA];
  endproperty
  a_quota_clr: assert property (p_quota_clr) else $error("quota flag not cleared");

  property p_attach;
    plug_in_evt |=> !attach_pin_oe_n && event_flags[EVT_PLUG];
  endproperty
  a_attach: assert property (p_attach) else $error("attach not reported");

  property p_remove;
    unplug_evt && !plug_in_evt |=> attach_pin_oe_n && event_flags[EVT_UNPLUG];
  endproperty
  a_remove: assert property (p_remove) else $error("removal not reported");

  property p_cc;
    rd_event |=> reg_rdata[EVT_CC] == $past(fault_cond.over_limit);
  endproperty
  a_cc: assert property (p_cc) else $error("constant-current bit wrong");

  property p_profile_clr;
    profile_clr && (profile_a_set == 8'h00) && (profile_b_set == 8'h00) |=> profile_flags == 16'h0000;
  endproperty
  a_profile_clr: assert property (p_profile_clr) else $error("profile bits not cleared");
endmodule
`default_nettype wire

// *** bench/psf_host_model.sv ***
/*
  Host side of the serial management register port: single-byte reads and writes.
  Assumes the block takes a strobe on the rising edge and registers its answer on that same edge.
*/
`timescale 1ns/1ps
`default_nettype none
module psf_host_model
  import psf_pkg::*;
(
  // Clock
  input wire logic clock,
  // Register port
  output var psf_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata
);
  initial reg_req = '0;

  // A released bus shows the inverse, so stale addresses never look valid
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    reg_req.addr = a;
    reg_req.rd = 1'b1;
    @(posedge clock);
    #1;
    reg_req.rd = 1'b0;
    reg_req.addr = ~a;
    d = reg_rdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    #1;
    reg_req.addr = a;
    reg_req.wdata = v;
    reg_req.wr = 1'b1;
    @(posedge clock);
    #1;
    reg_req.wr = 1'b0;
    reg_req.addr = ~a;
    reg_req.wdata = ~v;
  endtask
endmodule
`default_nettype wire

// *** bench/psf_port_status_tb.sv ***
/*
  Self-checking bench of the port status block with a host model on the register port.
  Assumes the open-drain pins are pulled up when nobody drives them.
*/
`timescale 1ns/1ps
`default_nettype none
module psf_port_status_tb;
  import psf_pkg::*;
  logic clock = 0, rst = 1;
  psf_reg_req_t reg_req;
  logic [7:0] reg_rdata;
  psf_fault_cond_t fault_cond;
  logic port_power_enable, autorecovery_en, quota_reached, quota_enable, quota_clear_cmd;
  logic [1:0] quota_action_sel, stim_pair_index;
  logic alert_link, throttle_cond, light_load_cond, unplug_evt, plug_in_evt;
  logic load_draw_flag, emulating_flag, new_mode_sel;
  logic [7:0] profile_a_set, profile_b_set, control_pin_level;
  logic alert_pin_out, alert_pin_oe_n, attach_pin_out, attach_pin_oe_n;
  wire logic alert_pin_in = alert_pin_oe_n ? 1'b1 : alert_pin_out;
  wire logic attach_pin_in = attach_pin_oe_n ? 1'b1 : attach_pin_out;
  psf_mode_t mode;
  int fail_count = 0, n_compared = 0;
  logic [6:0] fc_tab [6] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h03};
  logic [7:0] fb_tab [6] = '{8'h40, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};

  always #5 clock = ~clock;

  psf_host_model host (.clock(clock), .reg_req(reg_req), .reg_rdata(reg_rdata));

  psf_port_status DUT (
    .clock(clock), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .fault_cond(fault_cond),
    .port_power_enable(port_power_enable), .autorecovery_en(autorecovery_en),
    .quota_reached(quota_reached), .quota_enable(quota_enable), .quota_clear_cmd(quota_clear_cmd),
    .quota_action_sel(quota_action_sel), .alert_link(alert_link), .throttle_cond(throttle_cond),
    .light_load_cond(light_load_cond), .unplug_evt(unplug_evt), .plug_in_evt(plug_in_evt),
    .load_draw_flag(load_draw_flag), .emulating_flag(emulating_flag),
    .stim_pair_index(stim_pair_index), .new_mode_sel(new_mode_sel),
    .profile_a_set(profile_a_set), .profile_b_set(profile_b_set),
    .control_pin_level(control_pin_level), .alert_pin_in(alert_pin_in),
    .alert_pin_out(alert_pin_out), .alert_pin_oe_n(alert_pin_oe_n),
    .attach_pin_in(attach_pin_in), .attach_pin_out(attach_pin_out),
    .attach_pin_oe_n(attach_pin_oe_n), .mode(mode));

  function automatic logic [7:0] misc_exp(input logic al_n, at_n, ld, em, input logic [1:0] ix);
    return {2'b00, ~al_n, ~at_n, ld, em, ix};
  endfunction

  task automatic end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string name);
    logic [7:0] d;
    host.rd(a, d);
    chk(name, exp, d);
  endtask

  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end

  initial begin
    logic [7:0] pa, pb;
    void'($urandom(56489));
    fault_cond = '0;
    {port_power_enable, quota_enable} = 2'b11;
    {autorecovery_en, quota_reached, quota_clear_cmd, alert_link, throttle_cond} = '0;
    {light_load_cond, unplug_evt, plug_in_evt, load_draw_flag, emulating_flag, new_mode_sel} = '0;
    {quota_action_sel, stim_pair_index, profile_a_set, profile_b_set, control_pin_level} = '0;
    cyc(2);
    rst = 0;
    rdchk(ADDR_FAULT_STATE, FAULT_FLAGS_RESET, "reset_flag");
    rdchk(ADDR_FAULT_STATE, 8'h00, "reset_flag_read");
    chk("alert_pin", 8'h01, {7'h0, alert_pin_oe_n});
    host.wr(ADDR_FAULT_STATE, 8'hff);
    rdchk(ADDR_FAULT_STATE, 8'h00, "err_write_one");
    rdchk(8'h20, 8'h00, "unmapped");
    for (int i = 0; i < 6; i++) begin
      fault_cond = fc_tab[i];
      cyc(2);
      chk("mode_err", 8'(PSF_ERROR), 8'(mode));
      chk("alert_fault", 8'h00, {7'h0, alert_pin_oe_n});
      rdchk(ADDR_MISC_STATE, misc_exp(0, 1, 0, 0, 2'b00), "misc_alert");
      rdchk(ADDR_FAULT_STATE, 8'h80 | fb_tab[i], "fault_live");
      host.wr(ADDR_FAULT_STATE, 8'h00);
      chk("mode_kept", 8'(PSF_ERROR), 8'(mode));
      fault_cond = '0;
      host.wr(ADDR_FAULT_STATE, 8'h00);
      chk("mode_back", 8'(PSF_ACTIVE), 8'(mode));
      rdchk(ADDR_FAULT_STATE, 8'h00, "fault_cleared");
      chk("alert_free", 8'h01, {7'h0, alert_pin_oe_n});
    end
    fault_cond = 7'h02;
    cyc(2);
    rdchk(ADDR_FAULT_STATE, 8'h00, "limit_only");
    rdchk(ADDR_EVENT_STATE, 8'h10, "const_current");
    fault_cond = 7'h10;
    cyc(2);
    fault_cond = '0;
    port_power_enable = 0;
    cyc(3);
    rdchk(ADDR_FAULT_STATE, 8'h00, "power_off");
    port_power_enable = 1;
    autorecovery_en = 1;
    fault_cond = 7'h08;
    cyc(2);
    fault_cond = '0;
    for (int k = 0; k < 10 && mode !== PSF_ACTIVE; k++) cyc(1);
    chk("auto_recover", 8'(PSF_ACTIVE), 8'(mode));
    autorecovery_en = 0;
    plug_in_evt = 1;
    cyc(1);
    plug_in_evt = 0;
    chk("attach_pin", 8'h00, {7'h0, attach_pin_oe_n});
    chk("alert_attach", 8'h01, {7'h0, alert_pin_oe_n});
    for (int i = 0; i < 4; i++) begin
      stim_pair_index = 2'(i);
      {load_draw_flag, emulating_flag} = 2'($urandom);
      rdchk(ADDR_MISC_STATE, misc_exp(1, 0, load_draw_flag, emulating_flag, 2'(i)), "misc");
    end
    rdchk(ADDR_EVENT_STATE, 8'h01, "plug_flag");
    unplug_evt = 1;
    cyc(1);
    unplug_evt = 0;
    chk("attach_rel", 8'h01, {7'h0, attach_pin_oe_n});
    rdchk(ADDR_EVENT_STATE, 8'h02, "unplug_flag");
    rdchk(ADDR_EVENT_STATE, 8'h00, "unplug_read");
    for (int l = 0; l < 2; l++) begin
      alert_link = l[0];
      {throttle_cond, light_load_cond} = 2'b11;
      cyc(1);
      {throttle_cond, light_load_cond} = 2'b00;
      cyc(1);
      chk("alert_link", {7'h0, ~l[0]}, {7'h0, alert_pin_oe_n});
      rdchk(ADDR_EVENT_STATE, 8'h0c, "throttle_light");
      rdchk(ADDR_EVENT_STATE, 8'h00, "throttle_read");
    end
    for (int s = 0; s < 4; s++) begin
      quota_action_sel = 2'(s);
      quota_reached = 1;
      cyc(1);
      quota_reached = 0;
      cyc(1);
      chk("quota_alert", {7'h0, 2'(s) != QUOTA_ACT_ALERT}, {7'h0, alert_pin_oe_n});
      rdchk(ADDR_EVENT_STATE, 8'h80, "quota");
      quota_reached = 1;
      cyc(1);
      quota_reached = 0;
      {quota_clear_cmd, quota_enable} = s[0] ? 2'b11 : 2'b00;
      cyc(1);
      {quota_clear_cmd, quota_enable} = 2'b01;
      rdchk(ADDR_EVENT_STATE, 8'h00, "quota_clear");
    end
    pa = 8'($urandom);
    pb = 8'($urandom);
    control_pin_level = 8'($urandom);
    profile_a_set = pa;
    profile_b_set = pb;
    cyc(1);
    {profile_a_set, profile_b_set} = '0;
    rdchk(ADDR_PROFILE_A, pa & PROFILE_MASK[7:0], "profile_a");
    rdchk(ADDR_PROFILE_B, pb & PROFILE_MASK[15:8], "profile_b");
    chk("pins_profile", 8'h03, {6'h0, alert_pin_oe_n, attach_pin_oe_n});
    rdchk(ADDR_PIN_STATE, control_pin_level, "pin_state");
    new_mode_sel = 1;
    cyc(1);
    new_mode_sel = 0;
    rdchk(ADDR_PROFILE_A, 8'h00, "profile_new_mode");
    end_of_test();
  end
endmodule
`default_nettype wire
